/* File: pahs_pkg.sv */
// Constants and carrier types for the port ASPM and hot-plug slot registers.
// Assumes one 50 MHz core clock shared by every user of this package.
package pahs_pkg;

  // Configuration offsets (byte addresses)
  localparam logic [7:0] PM_CSR_OFS = 8'h44;
  localparam logic [7:0] LINK_CAP_OFS = 8'h74;
  localparam logic [7:0] LINK_CTL_OFS = 8'h78;
  localparam logic [7:0] SLOT_CAP_OFS = 8'h7c;
  localparam logic [7:0] SLOT_CSR_OFS = 8'h80;

  // Link capability fields
  localparam int LCAP_ASPM_LSB = 10;
  localparam int LCAP_L0S_LSB = 12;
  localparam int LCAP_L1_LSB = 15;
  localparam logic [1:0] ASPM_SUP_L0S = 2'h1;
  localparam logic [1:0] ASPM_SUP_BOTH = 2'h3;
  localparam logic [2:0] L1_LAT_5G = 3'h1;
  localparam logic [2:0] L1_LAT_2G5 = 3'h2;
  localparam logic [3:0] SYM_NS_5G = 4'h2;
  localparam logic [3:0] SYM_NS_2G5 = 4'h4;
  localparam logic [3:0] SYM_PER_FTS = 4'h4;

  // Link control fields
  localparam int LCTL_ASPM_LSB = 0;
  localparam int LCTL_CLKPM_BIT = 8;

  // Slot capability fields
  localparam int SCAP_PWRCTL_BIT = 1;
  localparam int SCAP_LATCH_BIT = 2;
  localparam int SCAP_ATNIND_BIT = 3;
  localparam int SCAP_PWRIND_BIT = 4;
  localparam int SCAP_SPLV_LSB = 7;
  localparam int SCAP_SPLS_LSB = 15;
  localparam logic [6:0] SCAP_PRES_RST = 7'h5f;
  localparam logic [7:0] SPL_VALUE_RST = 8'h19;
  localparam logic [1:0] SPL_SCALE_RST = 2'h0;

  // Slot control and status fields
  localparam int SCTL_PFDE_BIT = 1;
  localparam int SCTL_ATN_LSB = 6;
  localparam int SCTL_PIND_LSB = 8;
  localparam int SCTL_PCC_BIT = 10;
  localparam int SSTS_PFD_BIT = 17;
  localparam int SSTS_CC_BIT = 20;
  localparam logic [1:0] IND_ON = 2'h1;
  localparam logic [1:0] IND_BLINK = 2'h2;
  localparam logic [1:0] IND_OFF = 2'h3;
  localparam logic IND_RST_OFF = 1'b1;

  // Power management control/status fields
  localparam int PM_STATE_LSB = 0;
  localparam int PM_PMEEN_BIT = 8;
  localparam int PM_PMESTS_BIT = 15;
  localparam logic [1:0] PM_D0 = 2'h0;
  localparam logic [1:0] PM_D3HOT = 2'h3;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int PWR_ON_DELAY_NS = 1000;
  localparam int PWR_ON_DELAY_CYC = (PWR_ON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pahs_cfg_req_t;

  typedef struct packed {
    logic send;
    logic [7:0] value;
    logic [1:0] scale;
  } pahs_spl_msg_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic ack;
    logic [1:0] aspm_sup;
    logic [1:0] aspm_ctl;
    logic clkpm;
    logic [6:0] scap;
    logic [7:0] spl_val;
    logic [1:0] spl_scale;
    logic pfd_en;
    logic [1:0] atn_ind;
    logic [1:0] pwr_ind;
    logic pcc;
    logic pfd;
    logic cmd_done;
    logic [1:0] pstate;
    logic pme_en;
    logic pme_sts;
    logic pf_q;
    logic dlup_q;
    logic spl_send;
    logic hp_irq;
    logic pme_msg;
    logic blink;
    logic atn_led_n;
    logic pwr_led_n;
  } pahs_state_t;

endpackage

/* File: pahs_regs.sv */
// Per-port link power-management and hot-plug slot configuration registers.
// Assumes config and init requests come from core-clock logic; latch and
// power-fault pins are asynchronous and are synchronised here.
//
// Notes on behaviour
// - ASPM support bits 11:10 read 01b for L0s only, 11b for both.
// - L0s exit latency comes from FTS count times four symbols times symbol time.
// - L0s exit latency reads 100b at 5.0 GT/s, 101b at 2.5 GT/s for FTS counts 64 to 124.
// - L1 exit latency bits 17:15 read 001b at 5.0, 010b at 2.5 GT/s.
// - Link control bits 1:0 gate L0s and L1 entry: off, L0s, L1, both.
// - Receiver may enter L0s receive state even when L0s entry is disabled.
// - Clock power management enable bit 8 is stored but does nothing.
// - Slot capability reads zero on upstream and NT; presence set if hot-plug capable.
// - Without power controller present, slot never powers up.
// - With power controller, slot powers up when latch closed and control clear.
// - Latch sensor present: low latch means closed; absent: latch ignored.
// - Attention LED inactive unless indicator present; then driven active low.
// - Power LED inactive unless indicator present; then driven active low.
// - Slot capability bit 5 is surprise removal, bit 6 hot-plug capable.
// - Slot power limit is value bits 14:7 times scale bits 16:15.
// - Init write to power limit or link-up sends a power limit message.
// - Power limit fields exist only while slot-implemented is set.
// - Power fault with detector enabled: interrupt in D0, PME in D3hot.
// - Power indicator reads state; nonzero write completes a command; 00b ignored.
// - Power indicator codes: 01b on, 10b blink, 11b off.
// - Power controller control 0 turns slot power on after delay, 1 off.
// - Slot status bit 17 sets on a reported power fault.
// - Power state field takes only D0 00b and D3hot 11b writes.
// - Hot-plug event in D3hot sets PME status; sends PME when enabled.
`timescale 1ns/1ps
`default_nettype none
module pahs_regs #(
  parameter int PWR_ON_CYCLES = pahs_pkg::PWR_ON_DELAY_CYC,
  parameter int BLINK_HALF_CYCLES = pahs_pkg::BLINK_HALF_CYC
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire pahs_pkg::pahs_cfg_req_t cfg_req_in,
  input wire pahs_pkg::pahs_cfg_req_t init_req_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_ack_out,
  input wire logic port_is_upstream_in,
  input wire logic nontransparent_port_in,
  input wire logic hp_capable_in,
  input wire logic slot_implemented_in,
  input wire logic link_speed_5g_in,
  input wire logic [7:0] fts_count_in,
  input wire logic dl_up_in,
  input wire logic slot_latch_n_in,
  input wire logic slot_power_fault_in,
  output logic aspm_l0s_enable_out,
  output logic aspm_l1_enable_out,
  output logic rx_l0s_allowed_out,
  output logic slot_power_enable_out,
  output logic slot_attention_led_n_out,
  output logic slot_power_led_n_out,
  output pahs_pkg::pahs_spl_msg_t spl_msg_out,
  output logic hp_interrupt_out,
  output logic pme_message_out
);
  import pahs_pkg::*;

  pahs_state_t st_r;
  pahs_state_t st_nxt;
  logic [1:0] pins_sync;
  logic latch_closed;
  logic pf_level;
  logic slot_ok;
  logic hp_ok;
  logic pwr_req;
  logic blink_tick;
  logic [11:0] l0s_ns;
  logic [2:0] l0s_code;
  logic [31:0] lcap_rd;
  logic [31:0] scap_rd;
  logic [31:0] sreg_rd;

  generate
    if (PWR_ON_CYCLES < 1 || BLINK_HALF_CYCLES < 1) begin : g_chk
      $error("pahs_regs needs positive timer counts");
    end
  endgenerate

  pahs_sync #(
    .WIDTH(2)
  ) u_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .async_in({slot_power_fault_in, slot_latch_n_in}),
    .sync_out(pins_sync)
  );

  assign latch_closed = ~pins_sync[0];
  assign pf_level = pins_sync[1];
  assign slot_ok = ~port_is_upstream_in & ~nontransparent_port_in;
  assign hp_ok = slot_ok & hp_capable_in;

  // Power on only with controller present, control clear, latch closed or no latch sensor
  assign pwr_req = hp_ok & st_r.scap[SCAP_PWRCTL_BIT] & ~st_r.pcc
                   & (latch_closed | ~st_r.scap[SCAP_LATCH_BIT]);

  pahs_timer #(
    .COUNT(PWR_ON_CYCLES)
  ) u_pwr_delay (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .run_in(pwr_req),
    .tick_out(),
    .level_out(slot_power_enable_out)
  );

  pahs_timer #(
    .COUNT(BLINK_HALF_CYCLES)
  ) u_blink (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .run_in(1'b1),
    .tick_out(blink_tick),
    .level_out()
  );

  // Exit latency code from nanoseconds, standard doubling bands
  function automatic logic [2:0] lat_code(input logic [11:0] ns);
    logic [2:0] c;
    c = 3'h7;
    if (ns < 12'd64) begin
      c = 3'h0;
    end else if (ns < 12'd128) begin
      c = 3'h1;
    end else if (ns < 12'd256) begin
      c = 3'h2;
    end else if (ns < 12'd512) begin
      c = 3'h3;
    end else if (ns < 12'd1000) begin
      c = 3'h4;
    end else if (ns < 12'd2000) begin
      c = 3'h5;
    end else if (ns < 12'd4000) begin
      c = 3'h6;
    end
    return c;
  endfunction

  function automatic logic led_drive(input logic present, input logic [1:0] code,
                                     input logic blink);
    logic n;
    n = 1'b1;
    if (present) begin
      case (code)
        IND_ON: n = 1'b0;
        IND_BLINK: n = blink;
        default: n = 1'b1;
      endcase
    end
    return n;
  endfunction

  // Symbol time halves at the higher rate
  assign l0s_ns = 12'(fts_count_in * SYM_PER_FTS
                  * (link_speed_5g_in ? SYM_NS_5G : SYM_NS_2G5));
  assign l0s_code = lat_code(l0s_ns);

  always_comb begin
    lcap_rd = '0;
    lcap_rd[LCAP_ASPM_LSB +: 2] = st_r.aspm_sup;
    lcap_rd[LCAP_L0S_LSB +: 3] = l0s_code;
    lcap_rd[LCAP_L1_LSB +: 3] = link_speed_5g_in ? L1_LAT_5G : L1_LAT_2G5;
  end

  always_comb begin
    scap_rd = '0;
    if (hp_ok) begin
      scap_rd[6:0] = st_r.scap;
    end
    if (slot_ok && slot_implemented_in) begin
      scap_rd[SCAP_SPLV_LSB +: 8] = st_r.spl_val;
      scap_rd[SCAP_SPLS_LSB +: 2] = st_r.spl_scale;
    end
  end

  always_comb begin
    sreg_rd = '0;
    if (hp_ok) begin
      sreg_rd[SCTL_PFDE_BIT] = st_r.pfd_en;
      sreg_rd[SCTL_ATN_LSB +: 2] = st_r.atn_ind;
      sreg_rd[SCTL_PIND_LSB +: 2] = st_r.pwr_ind;
      sreg_rd[SCTL_PCC_BIT] = st_r.pcc;
      sreg_rd[SSTS_PFD_BIT] = st_r.pfd;
      sreg_rd[SSTS_CC_BIT] = st_r.cmd_done;
    end
  end

  always_comb begin
    logic pf_ev;
    logic cmd_ev;
    logic pfd_clr;
    logic cc_clr;
    logic pme_clr;
    logic in_d3;
    logic iw;
    logic cw;
    pf_ev = 1'b0;
    cmd_ev = 1'b0;
    pfd_clr = 1'b0;
    cc_clr = 1'b0;
    pme_clr = 1'b0;
    in_d3 = (st_r.pstate == PM_D3HOT);
    iw = init_req_in.wr;
    cw = cfg_req_in.wr;
    st_nxt = st_r;
    st_nxt.ack = cfg_req_in.wr | cfg_req_in.rd;
    st_nxt.pf_q = pf_level;
    st_nxt.dlup_q = dl_up_in;

    // Read-only capability fields load only from the init path
    if (iw && init_req_in.addr == LINK_CAP_OFS && init_req_in.be[1]) begin
      if (init_req_in.wdata[LCAP_ASPM_LSB +: 2] == ASPM_SUP_L0S ||
          init_req_in.wdata[LCAP_ASPM_LSB +: 2] == ASPM_SUP_BOTH) begin
        st_nxt.aspm_sup = init_req_in.wdata[LCAP_ASPM_LSB +: 2];
      end
    end else if (iw && init_req_in.addr == SLOT_CAP_OFS) begin
      if (init_req_in.be[0]) begin
        st_nxt.scap = init_req_in.wdata[6:0];
        st_nxt.spl_val[0] = init_req_in.wdata[SCAP_SPLV_LSB];
      end
      if (init_req_in.be[1]) begin
        st_nxt.spl_val[7:1] = init_req_in.wdata[SCAP_SPLV_LSB + 1 +: 7];
        st_nxt.spl_scale[0] = init_req_in.wdata[SCAP_SPLS_LSB];
      end
      if (init_req_in.be[2]) begin
        st_nxt.spl_scale[1] = init_req_in.wdata[SCAP_SPLS_LSB + 1];
      end
    end

    if (cw && cfg_req_in.addr == LINK_CTL_OFS) begin
      if (cfg_req_in.be[0]) begin
        st_nxt.aspm_ctl = cfg_req_in.wdata[LCTL_ASPM_LSB +: 2];
      end
      if (cfg_req_in.be[1]) begin
        st_nxt.clkpm = cfg_req_in.wdata[LCTL_CLKPM_BIT];
      end
    end else if (cw && cfg_req_in.addr == SLOT_CSR_OFS && hp_ok) begin
      if (cfg_req_in.be[0]) begin
        st_nxt.pfd_en = cfg_req_in.wdata[SCTL_PFDE_BIT];
        if (cfg_req_in.wdata[SCTL_ATN_LSB +: 2] != 2'h0) begin
          st_nxt.atn_ind = cfg_req_in.wdata[SCTL_ATN_LSB +: 2];
          cmd_ev = 1'b1;
        end
      end
      if (cfg_req_in.be[1]) begin
        st_nxt.pcc = cfg_req_in.wdata[SCTL_PCC_BIT];
        if (cfg_req_in.wdata[SCTL_PIND_LSB +: 2] != 2'h0) begin
          st_nxt.pwr_ind = cfg_req_in.wdata[SCTL_PIND_LSB +: 2];
          cmd_ev = 1'b1;
        end
      end
      if (cfg_req_in.be[2]) begin
        pfd_clr = cfg_req_in.wdata[SSTS_PFD_BIT];
        cc_clr = cfg_req_in.wdata[SSTS_CC_BIT];
      end
    end else if (cw && cfg_req_in.addr == PM_CSR_OFS) begin
      if (cfg_req_in.be[0] && (cfg_req_in.wdata[PM_STATE_LSB +: 2] == PM_D0 ||
          cfg_req_in.wdata[PM_STATE_LSB +: 2] == PM_D3HOT)) begin
        st_nxt.pstate = cfg_req_in.wdata[PM_STATE_LSB +: 2];
      end
      if (cfg_req_in.be[1]) begin
        st_nxt.pme_en = cfg_req_in.wdata[PM_PMEEN_BIT];
        pme_clr = cfg_req_in.wdata[PM_PMESTS_BIT];
      end
    end

    // Fault edge from the slot power controller
    pf_ev = hp_ok & pf_level & ~st_r.pf_q;
    // Set wins over a clear in the same cycle
    st_nxt.pfd = (st_r.pfd & ~pfd_clr) | pf_ev;
    st_nxt.cmd_done = (st_r.cmd_done & ~cc_clr) | cmd_ev;
    st_nxt.pme_sts = (st_r.pme_sts & ~pme_clr)
                     | (in_d3 & hp_ok & (pf_ev | cmd_ev));
    st_nxt.hp_irq = pf_ev & st_r.pfd_en & (st_r.pstate == PM_D0);
    st_nxt.pme_msg = in_d3 & hp_ok & ((pf_ev & st_r.pfd_en)
                     | ((pf_ev | cmd_ev) & st_r.pme_en));

    // Message carries the fields as held after this cycle's load
    st_nxt.spl_send = slot_ok & slot_implemented_in &
                      ((iw && init_req_in.addr == SLOT_CAP_OFS &&
                        (init_req_in.be[0] | init_req_in.be[1] | init_req_in.be[2]))
                       | (dl_up_in & ~st_r.dlup_q));

    if (blink_tick) begin
      st_nxt.blink = ~st_r.blink;
    end
    st_nxt.atn_led_n = led_drive(hp_ok & st_r.scap[SCAP_ATNIND_BIT],
                                 st_r.atn_ind, st_r.blink);
    st_nxt.pwr_led_n = led_drive(hp_ok & st_r.scap[SCAP_PWRIND_BIT],
                                 st_r.pwr_ind, st_r.blink);

    st_nxt.rdata = '0;
    if (cfg_req_in.rd) begin
      if (cfg_req_in.addr == LINK_CAP_OFS) begin
        st_nxt.rdata = lcap_rd;
      end else if (cfg_req_in.addr == LINK_CTL_OFS) begin
        st_nxt.rdata[LCTL_ASPM_LSB +: 2] = st_r.aspm_ctl;
        st_nxt.rdata[LCTL_CLKPM_BIT] = st_r.clkpm;
      end else if (cfg_req_in.addr == SLOT_CAP_OFS) begin
        st_nxt.rdata = scap_rd;
      end else if (cfg_req_in.addr == SLOT_CSR_OFS) begin
        st_nxt.rdata = sreg_rd;
      end else if (cfg_req_in.addr == PM_CSR_OFS) begin
        st_nxt.rdata[PM_STATE_LSB +: 2] = st_r.pstate;
        st_nxt.rdata[PM_PMEEN_BIT] = st_r.pme_en;
        st_nxt.rdata[PM_PMESTS_BIT] = st_r.pme_sts;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
      st_r.aspm_sup <= ASPM_SUP_BOTH;
      st_r.scap <= SCAP_PRES_RST;
      st_r.spl_val <= SPL_VALUE_RST;
      st_r.spl_scale <= SPL_SCALE_RST;
      st_r.atn_ind <= IND_OFF;
      st_r.pwr_ind <= IND_OFF;
      st_r.pstate <= PM_D0;
      st_r.atn_led_n <= IND_RST_OFF;
      st_r.pwr_led_n <= IND_RST_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_rdata_out = st_r.rdata;
  assign cfg_ack_out = st_r.ack;
  assign aspm_l0s_enable_out = st_r.aspm_ctl[0];
  assign aspm_l1_enable_out = st_r.aspm_ctl[1];
  // Receive side L0s is never gated by the enable field
  assign rx_l0s_allowed_out = 1'b1;
  assign slot_attention_led_n_out = st_r.atn_led_n;
  assign slot_power_led_n_out = st_r.pwr_led_n;
  assign spl_msg_out.send = st_r.spl_send;
  assign spl_msg_out.value = st_r.spl_val;
  assign spl_msg_out.scale = st_r.spl_scale;
  assign hp_interrupt_out = st_r.hp_irq;
  assign pme_message_out = st_r.pme_msg;
endmodule
`default_nettype wire

/* File: pahs_regs_properties.sv */
// Port-level checks for pahs_regs.
// Assumes it is bound to pahs_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pahs_regs_properties
  import pahs_pkg::*;
#(
  parameter int PWR_ON_CYCLES = 2,
  parameter int BLINK_HALF_CYCLES = 4
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire pahs_pkg::pahs_cfg_req_t cfg_req_in,
  input wire pahs_pkg::pahs_cfg_req_t init_req_in,
  input wire logic port_is_upstream_in,
  input wire logic nontransparent_port_in,
  input wire logic hp_capable_in,
  input wire logic slot_implemented_in,
  input wire logic dl_up_in,
  input wire logic slot_power_fault_in,
  input wire logic aspm_l0s_enable_out,
  input wire logic aspm_l1_enable_out,
  input wire logic rx_l0s_allowed_out,
  input wire logic slot_power_enable_out,
  input wire logic slot_attention_led_n_out,
  input wire logic slot_power_led_n_out,
  input wire pahs_pkg::pahs_spl_msg_t spl_msg_out,
  input wire logic hp_interrupt_out
);
  logic dn_hp;
  logic [1:0] aspm_wr_r;
  assign dn_hp = !port_is_upstream_in && !nontransparent_port_in && hp_capable_in;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aspm_wr_r <= 2'h0;
    end else begin
      aspm_wr_r <= cfg_req_in.wdata[1:0];
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence slot_wr(b);
    cfg_req_in.wr && cfg_req_in.addr == SLOT_CSR_OFS && cfg_req_in.be[b] && dn_hp;
  endsequence
  rx_l0s_kept_a: assert property (rx_l0s_allowed_out)
    else $error("receiver L0s permission dropped");
  aspm_gate_a: assert property (
    cfg_req_in.wr && cfg_req_in.addr == LINK_CTL_OFS && cfg_req_in.be[0]
    |=> {aspm_l1_enable_out, aspm_l0s_enable_out} == aspm_wr_r)
    else $error("ASPM enables differ from written field");
  pwr_led_on_a: assert property (
    slot_wr(1) ##0 cfg_req_in.wdata[9:8] == IND_ON |-> ##2 !slot_power_led_n_out)
    else $error("power LED not lit");
  atn_led_on_a: assert property (
    slot_wr(0) ##0 cfg_req_in.wdata[7:6] == IND_ON |-> ##2 !slot_attention_led_n_out)
    else $error("attention LED not lit");
  pcc_off_a: assert property (
    slot_wr(1) ##0 cfg_req_in.wdata[SCTL_PCC_BIT] |-> ##[1:4] !slot_power_enable_out)
    else $error("slot power not removed");
  spl_init_a: assert property (
    init_req_in.wr && init_req_in.addr == SLOT_CAP_OFS && (|init_req_in.be[2:0])
    && !port_is_upstream_in && !nontransparent_port_in && slot_implemented_in
    |=> spl_msg_out.send)
    else $error("no power limit message after load");
  spl_link_a: assert property (
    $rose(dl_up_in) && !port_is_upstream_in && !nontransparent_port_in
    && slot_implemented_in |=> spl_msg_out.send)
    else $error("no power limit message after link up");
  irq_cause_a: assert property (
    hp_interrupt_out |-> $past(slot_power_fault_in, 2))
    else $error("interrupt without power fault");
endmodule
`default_nettype wire

/* File: pahs_slot_model.sv */
// Slot hardware stand-in: retention latch and power controller fault pin.
// Assumes the bench drives latch and fault requests on the core clock.
`timescale 1ns/1ps
`default_nettype none
module pahs_slot_model (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic latch_open_in,
  input wire logic fault_in,
  output logic slot_latch_n_out,
  output logic slot_power_fault_out
);
  // Latch reads closed (low) from reset
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slot_latch_n_out <= 1'b0;
      slot_power_fault_out <= 1'b0;
    end else begin
      slot_latch_n_out <= latch_open_in;
      slot_power_fault_out <= fault_in;
    end
  end
endmodule
`default_nettype wire

/* File: pahs_sync.sv */
// Two-stage synchroniser for levels that arrive from pins.
// Assumes the inputs change slowly against the core clock.
`timescale 1ns/1ps
`default_nettype none
module pahs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("pahs_sync needs WIDTH of at least one");
    end
  endgenerate

  // First stage feeds only the second stage
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* File: pahs_timer.sv */
// Cycle counter: pulses every COUNT cycles while run_in is high and
// holds level_out high from the first expiry until run_in drops.
// Assumes run_in comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pahs_timer #(
  parameter int COUNT = 50
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  output logic tick_out,
  output logic level_out
);
  localparam int W = $clog2(COUNT + 1);
  localparam logic [W-1:0] LAST = W'(COUNT - 1);
  logic [W-1:0] cnt_r;

  generate
    if (COUNT < 1) begin : g_chk
      $error("pahs_timer needs COUNT of at least one");
    end
  endgenerate

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
      tick_out <= 1'b0;
      level_out <= 1'b0;
    end else if (!run_in) begin
      cnt_r <= '0;
      tick_out <= 1'b0;
      level_out <= 1'b0;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
      tick_out <= 1'b1;
      level_out <= 1'b1;
    end else begin
      cnt_r <= cnt_r + W'(1);
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for pahs_regs with a slot hardware model.
// Assumes pahs_slot_model and the bound property checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pahs_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [3:0] be;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
    logic [2:0] oi;
    logic ov;
  } pahs_row_t;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  pahs_cfg_req_t cfg_req = '0;
  pahs_cfg_req_t init_req = '0;
  logic up = 1'b0;
  logic spd = 1'b0;
  logic [7:0] fts = 8'h40;
  logic dl_up = 1'b0;
  logic latch_open = 1'b0;
  logic fault = 1'b0;
  logic latch_n, pfault, ack, l0s, l1, rx_l0s, pwr_en, atn_n, pwr_n, irq, pme;
  logic [31:0] rdata;
  logic [31:0] rdat;
  logic [7:0] obs;
  logic [1:0] seen;
  pahs_spl_msg_t spl;
  int n_errors = 0;
  int cmp_count = 0;
  pahs_row_t rows [8] = '{
    '{8'h78, 4'h1, 32'h0, 32'h3, 32'h0, 3'h6, 1'b0},
    '{8'h78, 4'h1, 32'h1, 32'h3, 32'h1, 3'h6, 1'b1},
    '{8'h78, 4'h1, 32'h2, 32'h3, 32'h2, 3'h7, 1'b1},
    '{8'h78, 4'h2, 32'h100, 32'h103, 32'h102, 3'h7, 1'b1},
    '{8'h80, 4'h2, 32'h100, 32'h300, 32'h100, 3'h4, 1'b0},
    '{8'h80, 4'h2, 32'h300, 32'h300, 32'h300, 3'h4, 1'b1},
    '{8'h80, 4'h1, 32'h40, 32'hc0, 32'h40, 3'h5, 1'b0},
    '{8'h7c, 4'hf, 32'hffff_ffff, 32'h1_ffff, 32'hcdf, 3'h5, 1'b0}
  };
  assign obs = {l1, l0s, atn_n, pwr_n, pme, irq, spl.send, pwr_en};
  pahs_regs #(.PWR_ON_CYCLES(2), .BLINK_HALF_CYCLES(4)) u_pahs_regs (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .cfg_req_in(cfg_req), .init_req_in(init_req),
    .cfg_rdata_out(rdata), .cfg_ack_out(ack), .port_is_upstream_in(up),
    .nontransparent_port_in(1'b0), .hp_capable_in(1'b1), .slot_implemented_in(1'b1),
    .link_speed_5g_in(spd), .fts_count_in(fts), .dl_up_in(dl_up), .slot_latch_n_in(latch_n),
    .slot_power_fault_in(pfault), .aspm_l0s_enable_out(l0s), .aspm_l1_enable_out(l1),
    .rx_l0s_allowed_out(rx_l0s), .slot_power_enable_out(pwr_en),
    .slot_attention_led_n_out(atn_n), .slot_power_led_n_out(pwr_n), .spl_msg_out(spl),
    .hp_interrupt_out(irq), .pme_message_out(pme));
  pahs_slot_model u_pahs_slot_model (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .latch_open_in(latch_open), .fault_in(fault), .slot_latch_n_out(latch_n),
    .slot_power_fault_out(pfault));
  task automatic end_of_test();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] sv, input logic [31:0] ev);
    cmp_count++;
    if (sv !== ev) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, sv, ev);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d);
    @(posedge clock_in) cfg_req <= '{w, !w, a, b, d};
    @(posedge clock_in) cfg_req <= '0;
    // Answer stands only in the cycle after the taking edge
    #1;
    chk(32'(ack), 32'h1);
    rdat = rdata;
  endtask
  // Pulses stand one cycle, so every cycle is looked at
  task automatic wait_obs(input int i, input logic v);
    int k;
    for (k = 0; k < 24; k++) begin
      #1;
      if (obs[i] === v) break;
      @(posedge clock_in);
    end
    chk(32'(k < 24), 32'h1);
    if (k == 24) end_of_test();
  endtask
  initial begin
    forever #10 clock_in = ~clock_in;
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clock_in);
    rst_n_in <= 1'b1;
    foreach (rows[r]) begin
      acc(1'b1, rows[r].a, rows[r].be, rows[r].d);
      acc(1'b0, rows[r].a, 4'hf, 32'h0);
      chk(rdat & rows[r].m, rows[r].e);
      chk(32'(obs[rows[r].oi]), 32'(rows[r].ov));
    end
    // L0s entry is disabled here, receive side must stay allowed
    chk(32'(rx_l0s), 32'h1);
    // Mid-run reset brings back the register defaults
    @(posedge clock_in) rst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    acc(1'b0, SLOT_CSR_OFS, 4'hf, 32'h0);
    chk(rdat & 32'h12_07c2, 32'h3c0);
    chk(32'(obs[7:4]), 32'h3);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_in) spd <= i[0];
      fts <= i[1] ? 8'h7c : 8'h40;
      acc(1'b0, LINK_CAP_OFS, 4'hf, 32'h0);
      chk(32'(rdat[17:10]), i[0] ? 32'h33 : 32'h57);
    end
    acc(1'b1, SLOT_CSR_OFS, 4'h2, 32'h100);
    acc(1'b1, SLOT_CSR_OFS, 4'h4, 32'h10_0000);
    acc(1'b1, SLOT_CSR_OFS, 4'h2, 32'h0);
    acc(1'b0, SLOT_CSR_OFS, 4'hf, 32'h0);
    chk(rdat & 32'h10_0300, 32'h100);
    acc(1'b1, SLOT_CSR_OFS, 4'h2, 32'h100);
    acc(1'b0, SLOT_CSR_OFS, 4'hf, 32'h0);
    chk(rdat & 32'h10_0300, 32'h10_0100);
    acc(1'b1, SLOT_CSR_OFS, 4'h2, 32'h200);
    seen = 2'h0;
    repeat (12) begin
      @(posedge clock_in) #1;
      seen[obs[4]] = 1'b1;
    end
    chk(32'(seen), 32'h3);
    wait_obs(0, 1'b1);
    acc(1'b1, SLOT_CSR_OFS, 4'h2, 32'h700);
    wait_obs(0, 1'b0);
    acc(1'b1, SLOT_CSR_OFS, 4'h2, 32'h300);
    wait_obs(0, 1'b1);
    @(posedge clock_in) latch_open <= 1'b1;
    wait_obs(0, 1'b0);
    @(posedge clock_in) latch_open <= 1'b0;
    wait_obs(0, 1'b1);
    acc(1'b1, SLOT_CSR_OFS, 4'h1, 32'h2);
    @(posedge clock_in) fault <= 1'b1;
    wait_obs(2, 1'b1);
    @(posedge clock_in) fault <= 1'b0;
    acc(1'b0, SLOT_CSR_OFS, 4'hf, 32'h0);
    chk(32'(rdat[17]), 32'h1);
    acc(1'b1, SLOT_CSR_OFS, 4'h4, 32'h2_0000);
    acc(1'b0, SLOT_CSR_OFS, 4'hf, 32'h0);
    chk(32'(rdat[17]), 32'h0);
    acc(1'b1, PM_CSR_OFS, 4'h3, 32'h103);
    @(posedge clock_in) fault <= 1'b1;
    wait_obs(3, 1'b1);
    @(posedge clock_in) fault <= 1'b0;
    acc(1'b1, PM_CSR_OFS, 4'h1, 32'h1);
    acc(1'b0, PM_CSR_OFS, 4'hf, 32'h0);
    chk(rdat & 32'h8103, 32'h8103);
    acc(1'b1, PM_CSR_OFS, 4'h3, 32'h8000);
    @(posedge clock_in) init_req <= '{1'b1, 1'b0, SLOT_CAP_OFS, 4'h7, 32'h1_155f};
    @(posedge clock_in) init_req <= '0;
    wait_obs(1, 1'b1);
    chk(32'({spl.value, spl.scale}), 32'haa);
    acc(1'b0, SLOT_CAP_OFS, 4'hf, 32'h0);
    chk(rdat & 32'h1_ffff, 32'h1_155f);
    @(posedge clock_in) dl_up <= 1'b1;
    wait_obs(1, 1'b1);
    @(posedge clock_in) up <= 1'b1;
    acc(1'b0, SLOT_CAP_OFS, 4'hf, 32'h0);
    chk(rdat, 32'h0);
    end_of_test();
  end
endmodule
bind pahs_regs pahs_regs_properties #(
  .PWR_ON_CYCLES(PWR_ON_CYCLES), .BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)
) u_pahs_regs_properties (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .cfg_req_in(cfg_req_in), .init_req_in(init_req_in), .port_is_upstream_in(port_is_upstream_in),
  .nontransparent_port_in(nontransparent_port_in), .hp_capable_in(hp_capable_in),
  .slot_implemented_in(slot_implemented_in), .dl_up_in(dl_up_in),
  .slot_power_fault_in(slot_power_fault_in), .aspm_l0s_enable_out(aspm_l0s_enable_out),
  .aspm_l1_enable_out(aspm_l1_enable_out), .rx_l0s_allowed_out(rx_l0s_allowed_out),
  .slot_power_enable_out(slot_power_enable_out),
  .slot_attention_led_n_out(slot_attention_led_n_out),
  .slot_power_led_n_out(slot_power_led_n_out), .spl_msg_out(spl_msg_out),
  .hp_interrupt_out(hp_interrupt_out));
`default_nettype wire
